// [hdl/pwm_three_phase_deadband_stage.sv]
`timescale 1ns/1ns
module pwm_three_phase_deadband_stage (
  input wire logic core_clk, // 10 MHz unit clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [3:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic period_evt, // period event pulse
  input wire logic rise_evt, // rising edge event pulse
  input wire logic fall_evt, // falling edge event pulse
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  output logic frac_carry, // accumulator overflow, stretch period
  output logic out_a, // phase 1 high / primary
  output logic out_b, // phase 1 low / complementary
  output logic out_c, // phase 2 high
  output logic out_d, // phase 2 low
  output logic out_e, // phase 3 high
  output logic out_f // phase 3 low
);
  import pwm_stage_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // isolate the lowest set steering bit
  function automatic logic [STEER_W-1:0] lowest_bit(input logic [STEER_W-1:0] v);
    logic [STEER_W-1:0] r;
    r = '0;
    for (int i = STEER_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : lowest_bit

  // true in modes with a complementary pair
  function automatic logic is_comp_mode(input logic [2:0] m);
    return (m == MODE_VF_COMP) || (m == MODE_COMP);
  endfunction : is_comp_mode

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic enable_q;
  logic [2:0] mode_q;
  logic rise_en_q;
  logic fall_en_q;
  logic load_pend_q;
  logic [DB_W-1:0] rise_time_q;
  logic [DB_W-1:0] fall_time_q;
  logic [DB_W-1:0] rise_act_q;
  logic [DB_W-1:0] fall_act_q;
  logic [FRAC_W-1:0] frac_set_q;
  logic [STEER_W-1:0] steer_q;
  logic hs_mod_q;
  logic ls_mod_q;

  // ---------------------------------------------------------------
  // waveform state
  // ---------------------------------------------------------------
  logic pwm_q;
  logic tp_q;
  logic freeze_q;
  logic [FRAC_W-1:0] acc_q;
  logic [2:0] mode_prev_q;
  fb_state_e fb_q;
  logic rise_busy;
  logic fall_busy;

  logic wr_main;
  logic comp_mode;
  logic rise_trig;
  logic fall_trig;
  logic fb_to_rev;
  logic fb_to_fwd;
  logic rise_start;
  logic fall_start;
  logic [FRAC_W:0] acc_sum;
  logic [STEER_W-1:0] steer_one;
  logic hi_lvl;
  logic lo_lvl;
  logic [5:0] outs_d;
  logic [5:0] outs_q;
  logic [7:0] rd_d;

  assign wr_main = reg_wr && (reg_addr == ADDR_MAIN_CONTROL);
  assign comp_mode = enable_q && is_comp_mode(mode_q);

  // ---------------------------------------------------------------
  // control register writes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_q <= 1'b0;
      mode_q <= RST_MODE;
      rise_en_q <= 1'b0;
      fall_en_q <= 1'b0;
    end else if (wr_main) begin
      enable_q <= reg_wdata[MC_ENABLE];
      mode_q <= reg_wdata[MC_MODE_LO +: 3];
      rise_en_q <= reg_wdata[MC_RISE_DB_EN];
      fall_en_q <= reg_wdata[MC_FALL_DB_EN];
    end
  end

  // data registers written by software
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rise_time_q <= RST_BYTE;
      fall_time_q <= RST_BYTE;
      frac_set_q <= RST_BYTE[FRAC_W-1:0];
      steer_q <= RST_BYTE[STEER_W-1:0];
      hs_mod_q <= 1'b0;
      ls_mod_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_RISE_DB_TIME) begin
        rise_time_q <= reg_wdata;
      end else if (reg_addr == ADDR_FALL_DB_TIME) begin
        fall_time_q <= reg_wdata;
      end else if (reg_addr == ADDR_FRAC_SETTING) begin
        frac_set_q <= reg_wdata[FRAC_W-1:0];
      end else if (reg_addr == ADDR_STEER_SELECT) begin
        steer_q <= reg_wdata[STEER_W-1:0];
      end else if (reg_addr == ADDR_STEER_CTRL_B) begin
        hs_mod_q <= reg_wdata[SC_HS_MOD_EN];
        ls_mod_q <= reg_wdata[SC_LS_MOD_EN];
      end
    end
  end

  // load request: set by software, cleared at a period event while enabled; set wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_pend_q <= 1'b0;
    end else if (wr_main && reg_wdata[MC_LOAD_REQ]) begin
      load_pend_q <= 1'b1;
    end else if (period_evt && enable_q) begin
      load_pend_q <= 1'b0;
    end
  end

  // working dead-band times: follow directly while disabled
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rise_act_q <= RST_BYTE;
      fall_act_q <= RST_BYTE;
    end else if (!enable_q || (period_evt && load_pend_q)) begin
      rise_act_q <= rise_time_q;
      fall_act_q <= fall_time_q;
    end
  end

  // ---------------------------------------------------------------
  // edge triggers per mode
  // ---------------------------------------------------------------
  // events arrive synchronous, so no extra clock of uncertainty
  always_comb begin
    rise_trig = 1'b0;
    fall_trig = 1'b0;
    if (enable_q && (mode_q == MODE_VF_COMP)) begin
      rise_trig = period_evt && !pwm_q;
      fall_trig = period_evt && pwm_q;
    end else if (enable_q && (mode_q != MODE_OFF) && (mode_q != MODE_3PHASE)) begin
      rise_trig = rise_evt;
      fall_trig = fall_evt && !rise_evt;
    end
  end

  // full-bridge direction change detection
  assign fb_to_rev = enable_q && (mode_q == MODE_FB_REV) && (mode_prev_q == MODE_FB_FWD);
  assign fb_to_fwd = enable_q && (mode_q == MODE_FB_FWD) && (mode_prev_q == MODE_FB_REV);

  // counter starts, gated by the live enables
  always_comb begin
    rise_start = 1'b0;
    fall_start = 1'b0;
    if (comp_mode) begin
      rise_start = rise_trig && rise_en_q;
      fall_start = fall_trig && fall_en_q;
    end else begin
      rise_start = fb_to_fwd && rise_en_q;
      fall_start = fb_to_rev && fall_en_q;
    end
  end

  // ---------------------------------------------------------------
  // dead-band counters
  // ---------------------------------------------------------------
  // rising counter, ended by a falling trigger
  deadband_counter u_rise_db (
    .core_clk(core_clk),
    .srst(srst),
    .start(rise_start),
    .kill(fall_trig || !enable_q),
    .limit(rise_act_q),
    .busy(rise_busy)
  );

  // falling counter, ended by a rising trigger
  deadband_counter u_fall_db (
    .core_clk(core_clk),
    .srst(srst),
    .start(fall_start),
    .kill(rise_trig || !enable_q),
    .limit(fall_act_q),
    .busy(fall_busy)
  );

  // ---------------------------------------------------------------
  // primary level and three-phase modulation level
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwm_q <= 1'b0;
    end else if (!enable_q || (mode_q != mode_prev_q)) begin
      pwm_q <= 1'b0;
    end else if (rise_trig) begin
      pwm_q <= 1'b1;
    end else if (fall_trig) begin
      pwm_q <= 1'b0;
    end
  end

  // three-phase edge level: rising event sets, falling event clears
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tp_q <= 1'b0;
    end else if (!enable_q || (mode_q != MODE_3PHASE)) begin
      tp_q <= 1'b0;
    end else if (rise_evt) begin
      tp_q <= 1'b1;
    end else if (fall_evt) begin
      tp_q <= 1'b0;
    end
  end

  // same-type overlap freezes outputs until the restarted count ends
  always_ff @(posedge core_clk) begin
    if (srst) begin
      freeze_q <= 1'b0;
    end else if (!comp_mode) begin
      freeze_q <= 1'b0;
    end else if ((rise_start && rise_busy) || (fall_start && fall_busy)) begin
      freeze_q <= 1'b1;
    end else if (!rise_busy && !fall_busy) begin
      freeze_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // fractional frequency accumulator
  // ---------------------------------------------------------------
  assign acc_sum = {1'b0, acc_q} + {1'b0, frac_set_q};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_q <= RST_BYTE[FRAC_W-1:0];
      frac_carry <= 1'b0;
    end else if (enable_q && (mode_q == MODE_VF_COMP) && period_evt) begin
      acc_q <= acc_sum[FRAC_W-1:0];
      frac_carry <= acc_sum[FRAC_W];
    end else begin
      frac_carry <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // full-bridge direction sequencer and mode history
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_prev_q <= RST_MODE;
      fb_q <= FB_FWD;
    end else begin
      mode_prev_q <= enable_q ? mode_q : MODE_OFF;
      case (fb_q)
        FB_FWD: begin
          if (fb_to_rev) begin
            fb_q <= FB_SWITCH;
          end
        end
        FB_REV: begin
          if (fb_to_fwd) begin
            fb_q <= FB_SWITCH;
          end
        end
        FB_SWITCH: begin
          if (!rise_start && !fall_start && !rise_busy && !fall_busy) begin
            fb_q <= (mode_q == MODE_FB_REV) ? FB_REV : FB_FWD;
          end
        end
        default: begin
          fb_q <= FB_FWD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output steering and drive
  // ---------------------------------------------------------------
  assign steer_one = lowest_bit(steer_q);
  assign hi_lvl = hs_mod_q ? tp_q : 1'b1;
  assign lo_lvl = ls_mod_q ? tp_q : 1'b1;

  // next output levels, order {f, e, d, c, b, a}
  always_comb begin
    outs_d = 6'h00;
    if (!enable_q) begin
      outs_d = 6'h00;
    end else if (comp_mode) begin
      if (freeze_q) begin
        outs_d = outs_q;
      end else begin
        outs_d[0] = pwm_q && !rise_busy;
        outs_d[1] = !pwm_q && !fall_busy;
      end
    end else if (mode_q == MODE_3PHASE) begin
      // one high-side (a, c, e) and one low-side (b, d, f) line at most
      if (steer_one[0]) begin
        outs_d = {2'b00, lo_lvl, 2'b00, hi_lvl};
      end else if (steer_one[1]) begin
        outs_d = {lo_lvl, 4'h0, hi_lvl};
      end else if (steer_one[2]) begin
        outs_d = {lo_lvl, 2'b00, hi_lvl, 2'b00};
      end else if (steer_one[3]) begin
        outs_d = {3'b000, hi_lvl, lo_lvl, 1'b0};
      end else if (steer_one[4]) begin
        outs_d = {1'b0, hi_lvl, 2'b00, lo_lvl, 1'b0};
      end else if (steer_one[5]) begin
        outs_d = {1'b0, hi_lvl, lo_lvl, 3'b000};
      end
    end else if ((mode_q == MODE_FB_FWD) && (fb_q == FB_FWD)) begin
      outs_d = {2'b00, 1'b1, 2'b00, pwm_q};
    end else if ((mode_q == MODE_FB_REV) && (fb_q == FB_REV)) begin
      outs_d = {3'b000, 1'b1, pwm_q, 1'b0};
    end
  end

  // registered pins, phase grouping a..f
  always_ff @(posedge core_clk) begin
    if (srst) begin
      outs_q <= 6'h00;
    end else begin
      outs_q <= outs_d;
    end
  end

  assign out_a = outs_q[0];
  assign out_b = outs_q[1];
  assign out_c = outs_q[2];
  assign out_d = outs_q[3];
  assign out_e = outs_q[4];
  assign out_f = outs_q[5];

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    if (reg_addr == ADDR_MAIN_CONTROL) begin
      rd_d = {1'b0, load_pend_q, fall_en_q, rise_en_q, mode_q, enable_q};
    end else if (reg_addr == ADDR_RISE_DB_TIME) begin
      rd_d = rise_time_q;
    end else if (reg_addr == ADDR_FALL_DB_TIME) begin
      rd_d = fall_time_q;
    end else if (reg_addr == ADDR_FRAC_SETTING) begin
      rd_d = {4'h0, frac_set_q};
    end else if (reg_addr == ADDR_STEER_SELECT) begin
      rd_d = {2'b00, steer_q};
    end else if (reg_addr == ADDR_STEER_CTRL_B) begin
      rd_d = {6'h00, ls_mod_q, hs_mod_q};
    end else if (reg_addr == ADDR_STATUS) begin
      rd_d[ST_RISE_BUSY] = rise_busy;
      rd_d[ST_FALL_BUSY] = fall_busy;
      rd_d[ST_FREEZE] = freeze_q;
      rd_d[ST_PWM] = pwm_q;
      rd_d[ST_ACC_LO +: FRAC_W] = acc_q;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : pwm_three_phase_deadband_stage

// [hdl/pwm_stage_pkg.sv]
package pwm_stage_pkg;

  // ---------------------------------------------------------------
  // register indices on the plain register port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_MAIN_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_RISE_DB_TIME = 4'h1;
  localparam logic [3:0] ADDR_FALL_DB_TIME = 4'h2;
  localparam logic [3:0] ADDR_FRAC_SETTING = 4'h3;
  localparam logic [3:0] ADDR_STEER_SELECT = 4'h4;
  localparam logic [3:0] ADDR_STEER_CTRL_B = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MC_ENABLE = 0;
  localparam int MC_MODE_LO = 1;
  localparam int MC_RISE_DB_EN = 4;
  localparam int MC_FALL_DB_EN = 5;
  localparam int MC_LOAD_REQ = 6;
  localparam int SC_HS_MOD_EN = 0;
  localparam int SC_LS_MOD_EN = 1;
  localparam int ST_RISE_BUSY = 0;
  localparam int ST_FALL_BUSY = 1;
  localparam int ST_FREEZE = 2;
  localparam int ST_PWM = 3;
  localparam int ST_ACC_LO = 4;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int DB_W = 8;
  localparam int FRAC_W = 4;
  localparam int STEER_W = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_MODE = 3'h0;

  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_VF_COMP = 3'h1;
  localparam logic [2:0] MODE_COMP = 3'h2;
  localparam logic [2:0] MODE_3PHASE = 3'h3;
  localparam logic [2:0] MODE_FB_FWD = 3'h4;
  localparam logic [2:0] MODE_FB_REV = 3'h5;

  // full-bridge direction sequencer
  typedef enum logic [2:0] {
    FB_FWD = 3'b001,
    FB_REV = 3'b010,
    FB_SWITCH = 3'b100
  } fb_state_e;

endpackage : pwm_stage_pkg

// [hdl/deadband_counter.sv]
`timescale 1ns/1ns
module deadband_counter (
  input wire logic core_clk, // unit clock
  input wire logic srst, // synchronous reset
  input wire logic start, // start or restart a delay
  input wire logic kill, // terminate a running delay
  input wire logic [pwm_stage_pkg::DB_W-1:0] limit, // delay length in cycles
  output logic busy // delay in progress
);
  import pwm_stage_pkg::*;

  logic [DB_W-1:0] cnt_q;
  logic [DB_W-1:0] cnt_inc;

  assign cnt_inc = cnt_q + 8'h01;

  // ---------------------------------------------------------------
  // counter: advances once per clock while running
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= RST_BYTE;
      busy <= 1'b0;
    end else if (start) begin
      cnt_q <= RST_BYTE;
      busy <= (limit != RST_BYTE); // zero time gives no hold-off
    end else if (kill) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt_q <= cnt_inc;
      if (cnt_inc == limit) begin
        busy <= 1'b0;
      end
    end
  end

endmodule : deadband_counter

// [tb/half_bridge_driver_model.sv]
`timescale 1ns/1ns
module half_bridge_driver_model (
  input wire logic core_clk, // unit clock
  input wire logic [5:0] gate, // gate commands, bit 0 is out_a
  output int shoot_cnt // cycles with a leg shorted
);
  int cnt_q = 0;
  // a leg shoots through when its high and low switch are both on
  always @(posedge core_clk) begin
    if ((gate[0] && gate[1]) || (gate[2] && gate[3]) || (gate[4] && gate[5])) begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign shoot_cnt = cnt_q;
endmodule : half_bridge_driver_model

// [tb/pwm_stage_checker_assertions.sv]
`timescale 1ns/1ns
module pwm_stage_checker (
  input wire logic core_clk, // clock
  input wire logic srst, // reset
  input wire logic [3:0] reg_addr, // index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic period_evt, // period event
  input wire logic [7:0] reg_rdata, // read data
  input wire logic frac_carry, // overflow
  input wire logic out_a, // 1H
  input wire logic out_b, // 1L
  input wire logic out_c, // 2H
  input wire logic out_d, // 2L
  input wire logic out_e, // 3H
  input wire logic out_f // 3L
);
  import pwm_stage_pkg::*;
  logic [7:0] ctl_q; // main control shadow
  logic [7:0] rt_q; // last rise time written
  logic [7:0] ft_q; // last fall time written
  logic [7:0] alow_q; // cycles out_a low
  logic [7:0] blow_q; // cycles out_b low
  logic [2:0] off_q; // cycles in an idle mode
  logic idle;
  logic vf;
  assign idle = ctl_q[3:1] == MODE_OFF || ctl_q[3:1] > MODE_FB_REV;
  assign vf = ctl_q[3:1] == MODE_VF_COMP && ctl_q[MC_ENABLE];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // shadow the bus writes and count low and idle time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctl_q <= RST_BYTE;
      rt_q <= RST_BYTE;
      ft_q <= RST_BYTE;
      alow_q <= 8'h00;
      blow_q <= 8'h00;
      off_q <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == ADDR_MAIN_CONTROL) ctl_q <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_RISE_DB_TIME) rt_q <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_FALL_DB_TIME) ft_q <= reg_wdata;
      alow_q <= out_a ? 8'h00 : alow_q + {7'h00, alow_q != 8'hFF};
      blow_q <= out_b ? 8'h00 : blow_q + {7'h00, blow_q != 8'hFF};
      off_q <= !idle ? 3'h0 : off_q + {2'h0, off_q != 3'h7};
    end
  end
  a_phase1_excl: assert property (!(out_a && out_b))
    else $error("phase 1 high and low both on");
  a_phase2_excl: assert property (!(out_c && out_d))
    else $error("phase 2 high and low both on");
  a_phase3_excl: assert property (!(out_e && out_f))
    else $error("phase 3 high and low both on");
  a_one_high: assert property ($onehot0({out_a, out_c, out_e}))
    else $error("more than one high side on");
  a_one_low: assert property ($onehot0({out_b, out_d, out_f}))
    else $error("more than one low side on");
  a_rise_gap: assert property ($rose(out_a) && vf && ctl_q[MC_RISE_DB_EN] && $past(vf, 4) |-> blow_q >= rt_q)
    else $error("primary on before rising dead time");
  a_fall_gap: assert property ($rose(out_b) && vf && ctl_q[MC_FALL_DB_EN] && $past(vf, 4) |-> alow_q >= ft_q)
    else $error("complementary on before falling dead time");
  a_carry_cause: assert property (frac_carry |-> $past(period_evt) || $past(period_evt, 2))
    else $error("carry without period event");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_rd: assert property ($past(reg_rd) && $past(reg_addr) > ADDR_STATUS |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_idle_quiet: assert property (off_q >= 3'h4 |-> {out_a, out_b, out_c, out_d, out_e, out_f} == 6'h00)
    else $error("outputs driven in idle mode");
endmodule : pwm_stage_checker

bind pwm_three_phase_deadband_stage pwm_stage_checker chk_i (.core_clk(core_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .period_evt(period_evt),
  .reg_rdata(reg_rdata), .frac_carry(frac_carry), .out_a(out_a), .out_b(out_b), .out_c(out_c),
  .out_d(out_d), .out_e(out_e), .out_f(out_f));

// [tb/pwm_three_phase_deadband_stage_test.sv]
`timescale 1ns/1ns
module pwm_three_phase_deadband_stage_test;
  import pwm_stage_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic period_evt = 1'b0;
  logic rise_evt = 1'b0;
  logic fall_evt = 1'b0;
  logic [7:0] reg_rdata;
  logic frac_carry;
  logic [5:0] outs; // out_f down to out_a
  logic [7:0] d;
  logic seen;
  int error_cnt = 0;
  int samples_checked = 0;
  int carries = 0;
  int shoot_cnt;
  int n;
  logic [5:0] pair [6] = '{6'b001001, 6'b100001, 6'b100100, 6'b000110, 6'b010010, 6'b011000};

  pwm_three_phase_deadband_stage uut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .period_evt(period_evt), .rise_evt(rise_evt),
    .fall_evt(fall_evt), .reg_rdata(reg_rdata), .frac_carry(frac_carry), .out_a(outs[0]), .out_b(outs[1]),
    .out_c(outs[2]), .out_d(outs[3]), .out_e(outs[4]), .out_f(outs[5]));
  half_bridge_driver_model drv (.core_clk(core_clk), .gate(outs), .shoot_cnt(shoot_cnt));

  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // count accumulator overflow pulses
  always @(posedge core_clk) begin
    if (frac_carry === 1'b1) begin
      carries++;
    end
  end

  // ---------------------------------------------------------------
  // bus and event tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  // one-cycle event pulse: 0 period, 1 rising, 2 falling
  task automatic ev(input int k);
    @(posedge core_clk);
    period_evt <= (k == 0);
    rise_evt <= (k == 1);
    fall_evt <= (k == 2);
    @(posedge core_clk);
    {period_evt, rise_evt, fall_evt} <= 3'b000;
  endtask : ev
  task automatic evchk(input int k, input logic [5:0] e);
    ev(k);
    repeat (3) @(posedge core_clk);
    #1;
    chk("outputs", {2'b00, outs}, {2'b00, e});
  endtask : evchk
  // edges until an output turns on, bounded
  task automatic hi(input int idx, output int c);
    c = 0;
    while (outs[idx] !== 1'b1 && c < 300) begin
      @(posedge core_clk);
      #1;
      c++;
    end
    if (c == 300) begin
      error_cnt++;
      finish_test();
    end
  endtask : hi
  task automatic watch(input int idx, input int cyc, output logic s);
    s = 1'b0;
    repeat (cyc) begin
      @(posedge core_clk);
      #1;
      s = s | outs[idx];
    end
  endtask : watch

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(i == 8 ? 4'hF : 4'(i), d);
      chk("reset read", d, 8'h00);
    end
    wr(ADDR_RISE_DB_TIME, 8'hFF);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_RISE_DB_TIME, d);
    chk("rise time", d, 8'hFF);
    rd(ADDR_STATUS, d);
    chk("status", d, 8'h00);
    // three-phase steering table, dead bands on but ignored
    wr(ADDR_MAIN_CONTROL, 8'h37);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_STEER_SELECT, 8'h01 << i);
      repeat (3) @(posedge core_clk);
      chk("pair", {2'b00, outs}, {2'b00, pair[i]});
      wr(ADDR_STEER_SELECT, (8'h3F << i) & 8'h3F);
      repeat (3) @(posedge core_clk);
      chk("lowest bit pair", {2'b00, outs}, {2'b00, pair[i]});
    end
    wr(ADDR_STEER_SELECT, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("no pair", {2'b00, outs}, 8'h00);
    wr(ADDR_STEER_SELECT, 8'h01);
    wr(ADDR_STEER_CTRL_B, 8'h01);
    evchk(2, 6'b001000);
    evchk(1, 6'b001001);
    wr(ADDR_STEER_CTRL_B, 8'h02);
    evchk(2, 6'b000001);
    evchk(1, 6'b001001);
    // variable frequency complementary
    wr(ADDR_MAIN_CONTROL, 8'h00);
    wr(ADDR_RISE_DB_TIME, 8'h05);
    wr(ADDR_FALL_DB_TIME, 8'h07);
    wr(ADDR_FRAC_SETTING, 8'h0F);
    wr(ADDR_MAIN_CONTROL, 8'h33);
    ev(0);
    hi(0, n);
    chk("rise gap", 8'(n >= 6 && n <= 9), 8'h01);
    rd(ADDR_STATUS, d);
    chk("accumulator", d >> 4, 8'h0F);
    ev(0);
    hi(1, n);
    chk("fall gap", 8'(n >= 8 && n <= 11), 8'h01);
    rd(ADDR_STATUS, d);
    chk("accumulator", d >> 4, 8'h0E);
    chk("carries", 8'(carries), 8'h01);
    wr(ADDR_MAIN_CONTROL, 8'h23);
    ev(0);
    hi(0, n);
    chk("rise no gap", 8'(n <= 4), 8'h01);
    ev(0);
    hi(1, n);
    wr(ADDR_MAIN_CONTROL, 8'h33);
    wr(ADDR_RISE_DB_TIME, 8'h00);
    ev(0);
    hi(0, n);
    chk("old rise time", 8'(n >= 6), 8'h01);
    ev(0);
    hi(1, n);
    wr(ADDR_MAIN_CONTROL, 8'h73);
    rd(ADDR_MAIN_CONTROL, d);
    chk("load pending", d, 8'h73);
    ev(0);
    hi(0, n);
    ev(0);
    hi(1, n);
    rd(ADDR_MAIN_CONTROL, d);
    chk("load done", d, 8'h33);
    ev(0);
    hi(0, n);
    chk("new rise time", 8'(n <= 4), 8'h01);
    // overlaps in event-driven complementary mode
    wr(ADDR_MAIN_CONTROL, 8'h00);
    wr(ADDR_RISE_DB_TIME, 8'h0A);
    wr(ADDR_MAIN_CONTROL, 8'h35);
    ev(1);
    ev(2);
    watch(0, 30, seen);
    chk("primary held", 8'(seen), 8'h00);
    chk("complementary on", 8'(outs[1]), 8'h01);
    ev(1);
    hi(0, n);
    ev(2);
    ev(1);
    watch(1, 30, seen);
    chk("complementary held", 8'(seen), 8'h00);
    chk("primary on", 8'(outs[0]), 8'h01);
    // falling then falling again while the falling count runs
    ev(2);
    ev(2);
    rd(ADDR_STATUS, d);
    chk("frozen status", d & 8'h07, 8'h06);
    chk("frozen pins", {2'b00, outs}, 8'h00);
    repeat (20) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    chk("resumed status", d & 8'h07, 8'h00);
    chk("resumed complementary", 8'(outs[1]), 8'h01);
    // full-bridge direction changes
    wr(ADDR_MAIN_CONTROL, 8'h39);
    repeat (4) @(posedge core_clk);
    chk("forward", {2'b00, outs}, 8'h08);
    wr(ADDR_MAIN_CONTROL, 8'h3B);
    hi(2, n);
    chk("reverse gap", 8'(n >= 7 && n <= 12), 8'h01);
    wr(ADDR_MAIN_CONTROL, 8'h39);
    hi(3, n);
    chk("forward gap", 8'(n >= 10 && n <= 15), 8'h01);
    chk("shoot through", 8'(shoot_cnt), 8'h00);
    finish_test();
  end
endmodule : pwm_three_phase_deadband_stage_test
